// file: src/piec_top.sv
// Purpose: Priority interrupt controller with eight-channel event transfer engine.
// Assumes: CPU returns vec_ack while vec_valid is high and raises psw_level itself.
// Notes:   Trap service is not nested in hardware; trap_ret ends all trap service.
`timescale 1ns/100ps
module piec_top #(
    parameter int NS = piec_pkg::N_SRC,
    parameter int NC = piec_pkg::N_CH,
    parameter int NT = piec_pkg::N_TRAP
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          wb_cyc,
    input  wire logic          wb_stb,
    input  wire logic          wb_we,
    input  wire logic [11:0]   wb_adr,
    input  wire logic [3:0]    wb_sel,
    input  wire logic [31:0]   wb_dat_w,
    output logic      [31:0]   wb_dat_r,
    output logic               wb_ack,
    input  wire logic [NS-1:0] src_req,
    input  wire logic [NT-1:0] fault_evt,
    input  wire logic          sw_trap,
    input  wire logic [7:0]    sw_trap_num,
    input  wire logic [3:0]    psw_level,
    input  wire logic          trap_ret,
    input  wire logic          vec_ack,
    output logic               vec_valid,
    output logic      [7:0]    vec_num,
    output logic      [1:0]    vec_kind,
    output logic               save_state,
    output logic               xfer_req,
    output logic      [15:0]   xfer_src,
    output logic      [15:0]   xfer_dst,
    output logic               xfer_word
);
    localparam int SW = $clog2(NS);
    localparam int CW = $clog2(NC);
    localparam int TW = $clog2(NT);

    initial begin
        if (NS > 32 || NC != 8 || NT > 32 || NT < 2 || NS < 2
            || piec_pkg::LAT_MIN_CYC > piec_pkg::LAT_MAX_CYC) begin
            $error("piec_top: unsupported parameters");
        end
    end

    typedef struct packed {
        logic [NS-1:0]          req;
        logic [NS-1:0]          en;
        logic [NS-1:0]          route;
        logic [NS-1:0][3:0]     lvl;
        logic [NS-1:0][2:0]     chan;
        logic [NC-1:0][15:0]    cnt;
        logic [NC-1:0]          word;
        logic [NC-1:0]          incd;
        logic [NC-1:0]          cont;
        logic [NT-1:0]          fault;
        logic [NT-1:0]          tpend;
        logic                   sw_pend;
        logic [7:0]             sw_num;
        piec_pkg::piec_eng_type eng;
        logic [SW-1:0]          eng_src;
        logic                   bus_ph;
        logic                   ack;
        logic [31:0]            dat;
        logic                   vvalid;
        logic [7:0]             vnum;
        logic [1:0]             vkind;
        logic [SW-1:0]          vsrc;
        logic [TW-1:0]          vtrap;
        logic                   trap_act;
        logic [TW-1:0]          trap_idx;
        logic                   save;
        logic                   xreq;
        logic [15:0]            xsrc;
        logic [15:0]            xdst;
        logic                   xword;
        logic [7:0]             lat;
    } piec_state_type;

    piec_state_type r;
    piec_state_type next_r;

    function automatic logic [31:0] piec_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (d & m);
    endfunction : piec_merge

    piec_arb_if #(.N(NS), .LW(4)) arb_bus ();
    piec_arb #(.N(NS), .LW(4)) u_arb (.bus(arb_bus));

    logic           ram_we;
    logic [3:0]     ram_waddr;
    logic [15:0]    ram_wdata;
    logic [3:0]     ram_raddr_b;
    logic [15:0]    ram_rdata_a;
    logic [15:0]    ram_rdata_b;
    logic [3:0]     bus_ram_addr;

    // Word index 2*c holds the source pointer of channel c, 2*c+1 the destination.
    assign bus_ram_addr = {wb_adr[4:2], wb_adr[5]};

    piec_ptr_ram #(.AW(4), .DW(16)) u_ram (
        .clk_sys (clk_sys),
        .rst     (rst),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (ram_wdata),
        .raddr_a (bus_ram_addr),
        .raddr_b (ram_raddr_b),
        .rdata_a (ram_rdata_a),
        .rdata_b (ram_rdata_b)
    );

    always_comb begin
        arb_bus.req = r.req & r.en;
        arb_bus.lvl = r.lvl;
    end

    logic [2:0]  ch;
    logic [15:0] step;
    logic        trap_cand;
    logic [TW-1:0] trap_pick;
    logic [11:0] a;
    logic [31:0] img;
    logic        wr;

    always_comb begin
        next_r      = r;
        next_r.save = 1'b0;
        next_r.xreq = 1'b0;
        next_r.ack  = 1'b0;
        ram_we      = 1'b0;
        ram_waddr   = '0;
        ram_wdata   = '0;
        ch          = r.chan[r.eng_src];
        ram_raddr_b = {ch, 1'b0};
        step        = r.word[ch] ? 16'h0002 : 16'h0001;
        a           = {wb_adr[11:2], 2'b00};
        img         = '0;
        wr          = 1'b0;
        trap_cand   = 1'b0;
        trap_pick   = '0;

        // Lowest trap index has the highest priority.
        for (int t = NT - 1; t >= 0; t--) begin
            if (r.tpend[t]) begin
                trap_cand = 1'b1;
                trap_pick = t[TW-1:0];
            end
        end
        if (r.trap_act && trap_pick >= r.trap_idx) begin
            trap_cand = 1'b0;
        end

        // Event transfer engine.
        unique case (r.eng)
            piec_pkg::PIEC_IDLE: begin
                if (arb_bus.win_valid && r.route[arb_bus.win_idx] && !r.trap_act
                    && (r.cnt[r.chan[arb_bus.win_idx]] != 16'h0000
                        || r.cont[r.chan[arb_bus.win_idx]])) begin
                    next_r.eng_src = arb_bus.win_idx;
                    next_r.eng     = piec_pkg::PIEC_RD_SRC;
                end
            end
            piec_pkg::PIEC_RD_SRC: begin
                ram_raddr_b = {ch, 1'b0};
                next_r.eng  = piec_pkg::PIEC_RD_DST;
            end
            piec_pkg::PIEC_RD_DST: begin
                ram_raddr_b = {ch, 1'b1};
                next_r.xsrc = ram_rdata_b;
                next_r.eng  = piec_pkg::PIEC_MOVE;
            end
            piec_pkg::PIEC_MOVE: begin
                // One stolen cycle: a single pulse, the program keeps running.
                next_r.xreq  = 1'b1;
                next_r.xdst  = ram_rdata_b;
                next_r.xword = r.word[ch];
                ram_we       = 1'b1;
                ram_waddr    = {ch, r.incd[ch]};
                ram_wdata    = r.incd[ch] ? ram_rdata_b + step : r.xsrc + step;
                if (!r.cont[ch]) begin
                    next_r.cnt[ch] = r.cnt[ch] - 16'h0001;
                end
                next_r.req[r.eng_src] = 1'b0;
                next_r.eng = piec_pkg::PIEC_IDLE;
            end
        endcase

        // Latency counter: runs while a CPU candidate waits.
        if (arb_bus.win_valid && !r.vvalid && arb_bus.win_lvl > psw_level && !r.trap_act
            && (!r.route[arb_bus.win_idx] || (r.cnt[r.chan[arb_bus.win_idx]] == 16'h0000
                && !r.cont[r.chan[arb_bus.win_idx]]))) begin
            if (r.lat < 8'(piec_pkg::LAT_MIN_CYC - 1)) begin
                next_r.lat = r.lat + 8'h01;
            end else if (r.eng == piec_pkg::PIEC_IDLE) begin
                next_r.vvalid = 1'b1;
                next_r.vkind  = piec_pkg::PIEC_K_IRQ;
                next_r.vsrc   = arb_bus.win_idx;
                next_r.vnum   = piec_pkg::VEC_IRQ_BASE + 8'(arb_bus.win_idx);
                next_r.lat    = '0;
            end
        end else begin
            next_r.lat = '0;
        end

        // A waiting vector is replaced by a trap; a trap is never displaced.
        if (trap_cand && (!r.vvalid || r.vkind != piec_pkg::PIEC_K_TRAP)) begin
            next_r.vvalid = 1'b1;
            next_r.vkind  = piec_pkg::PIEC_K_TRAP;
            next_r.vtrap  = trap_pick;
            next_r.vnum   = piec_pkg::VEC_TRAP_BASE + 8'(trap_pick);
        end else if (r.sw_pend && !r.vvalid) begin
            next_r.vvalid = 1'b1;
            next_r.vkind  = piec_pkg::PIEC_K_SW;
            next_r.vnum   = r.sw_num;
        end

        if (r.vvalid && vec_ack) begin
            next_r.vvalid = 1'b0;
            next_r.save   = 1'b1;
            unique case (r.vkind)
                piec_pkg::PIEC_K_TRAP: begin
                    next_r.trap_act        = 1'b1;
                    next_r.trap_idx        = r.vtrap;
                    next_r.tpend[r.vtrap]  = 1'b0;
                end
                piec_pkg::PIEC_K_SW: next_r.sw_pend = 1'b0;
                default: next_r.req[r.vsrc] = 1'b0;
            endcase
        end
        if (trap_ret) begin
            next_r.trap_act = 1'b0;
        end
        if (sw_trap) begin
            next_r.sw_pend = 1'b1;
            next_r.sw_num  = sw_trap_num;
        end

        // Wishbone slave: answer on the edge after the one that sees the strobe.
        if (wb_cyc && wb_stb && !r.ack && !r.bus_ph && r.eng == piec_pkg::PIEC_IDLE) begin
            next_r.bus_ph = 1'b1;
        end else if (r.bus_ph && r.eng != piec_pkg::PIEC_MOVE) begin
            next_r.bus_ph = 1'b0;
            next_r.ack    = 1'b1;
            wr            = wb_we;
            if (a < piec_pkg::CH_CTL_BASE && 32'(a[11:2]) < NS) begin
                img = {16'h0000, r.req[a[SW+1:2]], 6'h00, r.chan[a[SW+1:2]],
                       r.route[a[SW+1:2]], r.en[a[SW+1:2]], r.lvl[a[SW+1:2]]};
                if (wr) begin
                    img = piec_merge(img, wb_dat_w, wb_sel);
                    next_r.lvl[a[SW+1:2]]   = img[piec_pkg::SC_LVL_LSB +: 4];
                    next_r.en[a[SW+1:2]]    = img[piec_pkg::SC_EN_BIT];
                    next_r.route[a[SW+1:2]] = img[piec_pkg::SC_ROUTE_BIT];
                    next_r.chan[a[SW+1:2]]  = img[piec_pkg::SC_CH_LSB +: 3];
                    next_r.req[a[SW+1:2]]   = img[piec_pkg::SC_REQ_BIT];
                end
            end else if (a >= piec_pkg::CH_CTL_BASE && a < piec_pkg::CH_CTL_BASE + 12'h020) begin
                img = {13'h0000, r.cont[a[4:2]], r.incd[a[4:2]], r.word[a[4:2]], r.cnt[a[4:2]]};
                if (wr) begin
                    img = piec_merge(img, wb_dat_w, wb_sel);
                    next_r.cnt[a[4:2]]  = img[piec_pkg::CC_CNT_LSB +: 16];
                    next_r.word[a[4:2]] = img[piec_pkg::CC_WORD_BIT];
                    next_r.incd[a[4:2]] = img[piec_pkg::CC_INCD_BIT];
                    next_r.cont[a[4:2]] = img[piec_pkg::CC_CONT_BIT];
                end
            end else if (a >= piec_pkg::SRC_PTR_BASE && a < piec_pkg::FAULT_OFS) begin
                img = {16'h0000, ram_rdata_a};
                if (wr) begin
                    img       = piec_merge(img, wb_dat_w, wb_sel);
                    ram_we    = 1'b1;
                    ram_waddr = bus_ram_addr;
                    ram_wdata = img[15:0];
                end
            end else if (a == piec_pkg::FAULT_OFS) begin
                img = 32'(r.fault);
                if (wr && wb_sel[0]) begin
                    next_r.fault = r.fault & ~wb_dat_w[NT-1:0];
                end
            end else if (a == piec_pkg::STATUS_OFS) begin
                img = {4'h0, r.vnum, 4'(r.eng), 3'h0, r.vvalid,
                       3'h0, r.trap_act, 1'b0, 5'(r.trap_idx), r.vkind};
            end
            next_r.dat = wr ? 32'h0000_0000 : img;
        end

        // Hardware sets win over any clear in the same cycle.
        next_r.req   = next_r.req | src_req;
        next_r.fault = next_r.fault | fault_evt;
        next_r.tpend = next_r.tpend | fault_evt;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r     <= '0;
            r.eng <= piec_pkg::PIEC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_r   = r.dat;
    assign wb_ack     = r.ack;
    assign vec_valid  = r.vvalid;
    assign vec_num    = r.vnum;
    assign vec_kind   = r.vkind;
    assign save_state = r.save;
    assign xfer_req   = r.xreq;
    assign xfer_src   = r.xsrc;
    assign xfer_dst   = r.xdst;
    assign xfer_word  = r.xword;
endmodule : piec_top

// file: src/piec_pkg.sv
// Purpose: Constants and types of the interrupt and event transfer controller.
// Assumes: One 125 MHz system clock, Wishbone register access with 32-bit data.
// Notes:   What this block does
// What this block does
// - Interrupt service starts 250 ns to 500 ns after the request.
// - Each source routes to vectored service or the event transfer engine.
// - An event transfer steals one cycle, with no vector branch.
// - A transfer moves a byte or word, then bumps one pointer.
// - Each transfer decrements the channel count, except in continuous mode.
// - Count zero outside continuous mode raises the source's standard interrupt instead.
// - The event transfer engine has eight independent channels.
// - Each source has a control register with request, enable and level.
// - The level field is four bits, sixteen priority levels.
// - Accepted service is preempted only by strictly higher priority.
// - Each source has its own fixed vector.
// - A software trap enters at the vector its number selects.
// - Faults raise non-maskable traps to a dedicated vector.
// - Each fault sets its own bit in the fault flag register.
// - A fault trap preempts all but an equal or higher trap in service.
// - Trap service holds off interrupts and event transfers.
// - Sources are arbitrated every cycle; a routed winner starts a transfer.
// - A CPU winner is taken only above the status word level.
// - On acknowledge the state is saved on the system stack first.
// - Count and control sit in registers, pointers in a dedicated RAM.
package piec_pkg;
    localparam int N_SRC  = 16;
    localparam int N_CH   = 8;
    localparam int N_TRAP = 8;
    localparam int LVL_W  = 4;

    localparam logic [11:0] SRC_CTL_BASE = 12'h000;
    localparam logic [11:0] CH_CTL_BASE  = 12'h080;
    localparam logic [11:0] SRC_PTR_BASE = 12'h0c0;
    localparam logic [11:0] DST_PTR_BASE = 12'h0e0;
    localparam logic [11:0] FAULT_OFS    = 12'h100;
    localparam logic [11:0] STATUS_OFS   = 12'h104;

    localparam int SC_LVL_LSB   = 0;
    localparam int SC_EN_BIT    = 4;
    localparam int SC_ROUTE_BIT = 5;
    localparam int SC_CH_LSB    = 6;
    localparam int SC_REQ_BIT   = 15;
    localparam int CC_CNT_LSB   = 0;
    localparam int CC_WORD_BIT  = 16;
    localparam int CC_INCD_BIT  = 17;
    localparam int CC_CONT_BIT  = 18;

    localparam logic [7:0] VEC_TRAP_BASE = 8'h00;
    localparam logic [7:0] VEC_IRQ_BASE  = 8'h20;

    localparam int CLK_MHZ     = 125;
    localparam int LAT_MIN_NS  = 250;
    localparam int LAT_MAX_NS  = 500;
    localparam int LAT_MIN_CYC = (LAT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int LAT_MAX_CYC = (LAT_MAX_NS * CLK_MHZ) / 1000;

    typedef enum logic [3:0] {
        PIEC_IDLE   = 4'b0001,
        PIEC_RD_SRC = 4'b0010,
        PIEC_RD_DST = 4'b0100,
        PIEC_MOVE   = 4'b1000
    } piec_eng_type;

    typedef enum logic [1:0] {
        PIEC_K_IRQ  = 2'h0,
        PIEC_K_TRAP = 2'h1,
        PIEC_K_SW   = 2'h2
    } piec_kind_type;
endpackage : piec_pkg

// file: src/piec_arb_if.sv
// Purpose: Carries pending requests to the arbiter and its winner back.
// Assumes: Purely combinational exchange within one clock domain.
// Notes:   None.
`timescale 1ns/100ps
interface piec_arb_if #(parameter int N = 16, parameter int LW = 4);
    logic [N-1:0]          req;
    logic [N-1:0][LW-1:0]  lvl;
    logic                  win_valid;
    logic [$clog2(N)-1:0]  win_idx;
    logic [LW-1:0]         win_lvl;
    modport arb  (input req, lvl, output win_valid, win_idx, win_lvl);
    modport user (output req, lvl, input win_valid, win_idx, win_lvl);
endinterface : piec_arb_if

// file: src/piec_arb.sv
// Purpose: Picks the pending source with the highest level.
// Assumes: Request vector already gated by the enables.
// Notes:   Strict compare keeps the lowest index on a tie.
`timescale 1ns/100ps
module piec_arb #(
    parameter int N  = 16,
    parameter int LW = 4
) (
    piec_arb_if.arb bus
);
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_idx   = '0;
        bus.win_lvl   = '0;
        for (int i = 0; i < N; i++) begin
            if (bus.req[i] && (!bus.win_valid || bus.lvl[i] > bus.win_lvl)) begin
                bus.win_valid = 1'b1;
                bus.win_idx   = i[$clog2(N)-1:0];
                bus.win_lvl   = bus.lvl[i];
            end
        end
    end
endmodule : piec_arb

// file: src/piec_ptr_ram.sv
// Purpose: Pointer store of the event transfer channels.
// Assumes: One write port, two read ports with registered data.
// Notes:   Read during write on the same word returns the old word.
`timescale 1ns/100ps
module piec_ptr_ram #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_a,
    output logic      [DW-1:0] rdata_b
);
    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              qa;
        logic [DW-1:0]              qb;
    } piec_ram_type;

    piec_ram_type r;
    piec_ram_type next_r;

    always_comb begin
        next_r    = r;
        next_r.qa = r.mem[raddr_a];
        next_r.qb = r.mem[raddr_b];
        if (we) begin
            next_r.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_a = r.qa;
    assign rdata_b = r.qb;
endmodule : piec_ptr_ram

// file: verif/piec_cpu_model.sv
// Purpose: Behavioural CPU core that takes vectors from the controller.
// Assumes: The bench sets the acknowledge delay, kept below 30 cycles.
// Notes:   A vector is recorded at the edge that samples the ack.
`timescale 1ns/100ps
module piec_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       vec_valid,
    input  wire logic [7:0] vec_num,
    input  wire logic [1:0] vec_kind,
    input  wire logic [7:0] ack_wait,
    output logic            vec_ack,
    output logic      [7:0] taken_num,
    output logic      [1:0] taken_kind,
    output logic      [7:0] n_taken
);
    logic [7:0] wait_cnt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vec_ack    <= 1'b0;
            wait_cnt   <= 8'h00;
            taken_num  <= 8'h00;
            taken_kind <= 2'h0;
            n_taken    <= 8'h00;
        end else begin
            vec_ack <= 1'b0;
            if (vec_ack && vec_valid) begin
                taken_num  <= vec_num;
                taken_kind <= vec_kind;
                n_taken    <= n_taken + 8'h01;
            end
            if (vec_valid && !vec_ack) begin
                wait_cnt <= wait_cnt + 8'h01;
                if (wait_cnt >= ack_wait) begin
                    vec_ack  <= 1'b1;
                    wait_cnt <= 8'h00;
                end
            end
        end
    end
endmodule : piec_cpu_model

// file: verif/piec_top_props.sv
// Purpose: Port-level checks of the interrupt controller.
// Assumes: One clock domain.
// Notes:   Trap service is tracked from the ack of a fault vector to trap_ret.
`timescale 1ns/100ps
module piec_top_props (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       wb_stb,
    input wire logic       wb_ack,
    input wire logic       vec_ack,
    input wire logic       vec_valid,
    input wire logic [7:0] vec_num,
    input wire logic [1:0] vec_kind,
    input wire logic       save_state,
    input wire logic       xfer_req,
    input wire logic       trap_ret
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic       in_trap;
    logic [3:0] trap_age;

    // The age lets a transfer already under way drain first.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            in_trap  <= 1'b0;
            trap_age <= 4'h0;
        end else begin
            if (vec_valid && vec_ack && vec_kind == 2'h1) in_trap <= 1'b1;
            else if (trap_ret) in_trap <= 1'b0;
            if (!in_trap) trap_age <= 4'h0;
            else if (trap_age != 4'hf) trap_age <= trap_age + 4'h1;
        end
    end

    property p_save; vec_valid && vec_ack |=> save_state && !vec_valid; endproperty
    a_save: assert property (p_save) else $error("no state save after ack");
    property p_save_cause; save_state |-> $past(vec_valid && vec_ack); endproperty
    a_save_cause: assert property (p_save_cause) else $error("stray state save");
    property p_xfer_one; xfer_req |=> !xfer_req; endproperty
    a_xfer_one: assert property (p_xfer_one) else $error("transfer over one cycle");
    property p_hold; vec_valid && !vec_ack |=> vec_valid; endproperty
    a_hold: assert property (p_hold) else $error("vector dropped before ack");
    property p_irq_num; vec_valid && vec_kind == 2'h0 |-> vec_num[7:4] == 4'h2; endproperty
    a_irq_num: assert property (p_irq_num) else $error("bad source vector");
    property p_trap_num; vec_valid && vec_kind == 2'h1 |-> vec_num[7:3] == 5'h00; endproperty
    a_trap_num: assert property (p_trap_num) else $error("bad trap vector");
    property p_trap_block;
        trap_age > 4'h5 |-> !xfer_req && !(vec_valid && vec_kind == 2'h0);
    endproperty
    a_trap_block: assert property (p_trap_block) else $error("service during trap");
    property p_ack; wb_ack |=> !wb_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");
    property p_ack_cause; wb_ack |-> $past(wb_stb) && wb_stb; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");

    c_xfer: cover property (xfer_req);
    c_trap: cover property (vec_valid && vec_ack && vec_kind == 2'h1);
    c_sw: cover property (vec_valid && vec_ack && vec_kind == 2'h2);
endmodule : piec_top_props

bind piec_top piec_top_props u_piec_top_props (.clk_sys, .rst, .wb_stb, .wb_ack, .vec_ack,
    .vec_valid, .vec_num, .vec_kind, .save_state, .xfer_req, .trap_ret);

// file: verif/piec_top_bench.sv
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: The bench plays peripherals, faults and the CPU status level.
// Notes:   Vectors are compared as the CPU model took them.
`timescale 1ns/100ps
module piec_top_bench;
    logic        clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack, sw_trap, trap_ret;
    logic        vec_ack, vec_valid, xfer_req, xfer_word, x_word;
    logic [11:0] wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, rd, x_sd;
    logic [3:0]  wb_sel, psw_level;
    logic [15:0] src_req, xfer_src, xfer_dst;
    logic [7:0]  fault_evt, sw_trap_num, vec_num, ack_wait, taken_num, n_taken;
    logic [1:0]  vec_kind, taken_kind;
    int          t, n_xfer, n_mismatch, checks_done;

    piec_top u_piec_top (.clk_sys, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .wb_dat_r, .wb_ack, .src_req, .fault_evt, .sw_trap, .sw_trap_num, .psw_level,
        .trap_ret, .vec_ack, .vec_valid, .vec_num, .vec_kind, .save_state(), .xfer_req,
        .xfer_src, .xfer_dst, .xfer_word);
    piec_cpu_model u_piec_cpu_model (.clk_sys, .rst, .vec_valid, .vec_num, .vec_kind,
        .ack_wait, .vec_ack, .taken_num, .taken_kind, .n_taken);

    always @(posedge clk_sys) begin
        if (xfer_req === 1'b1) begin
            n_xfer++;
            x_sd = {xfer_src, xfer_dst};
            x_word = xfer_word;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do @(posedge clk_sys); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic pulse(input logic [15:0] s, input logic [7:0] f);
        @(posedge clk_sys);
        src_req <= s;
        fault_evt <= f;
        @(posedge clk_sys);
        src_req <= 16'h0000;
        fault_evt <= 8'h00;
    endtask : pulse

    task automatic ret();
        @(posedge clk_sys);
        trap_ret <= 1'b1;
        @(posedge clk_sys);
        trap_ret <= 1'b0;
    endtask : ret

    // Waits for the n-th vector, counting edges in t.
    task automatic vec(input logic [7:0] n, input logic [31:0] exp);
        t = 0;
        while (n_taken !== n) begin
            @(posedge clk_sys);
            t++;
        end
        chk({22'h0, taken_kind, taken_num}, exp);
    endtask : vec

    task automatic xfer(input logic [15:0] s, input int n, input logic [31:0] sd,
                        input logic w);
        pulse(s, 8'h00);
        while (n_xfer != n) @(posedge clk_sys);
        chk(x_sd, sd);
        chk(x_word, w);
    endtask : xfer

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        #(8 * 20000);
        n_mismatch++;
        test_done();
    end

    initial begin
        {rst, wb_cyc, wb_stb, wb_we, sw_trap, trap_ret} = 6'h20;
        {wb_adr, wb_dat_w, wb_sel, psw_level} = 52'h0;
        {src_req, fault_evt, sw_trap_num, ack_wait} = 40'h0;
        wb_sel = 4'hf;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(12'h104, 32'h00010000);
        rdchk(12'h000, 32'h0);
        wb(1'b1, 12'h1fc, 32'hffffffff);
        rdchk(12'h1fc, 32'h0);
        wb(1'b1, 12'h00c, 32'hffff7fff);
        rdchk(12'h00c, 32'h1ff);
        wb(1'b1, 12'h00c, 32'h0);
        $display("test registers finished");
        wb(1'b1, 12'h008, 32'h17);
        wb(1'b1, 12'h014, 32'h17);
        ack_wait <= 8'h14;
        pulse(16'h0024, 8'h00);
        vec(8'h01, 32'h22);
        chk(t >= piec_pkg::LAT_MIN_CYC && t <= piec_pkg::LAT_MAX_CYC, 32'h1);
        rdchk(12'h008, 32'h17);
        psw_level <= 4'h7;
        repeat (80) @(posedge clk_sys);
        chk(n_taken, 32'h1);
        psw_level <= 4'h6;
        vec(8'h02, 32'h25);
        $display("test interrupts finished");
        ack_wait <= 8'h00;
        psw_level <= 4'h0;
        wb(1'b1, 12'h084, 32'h10002);
        wb(1'b1, 12'h0c4, 32'h1000);
        wb(1'b1, 12'h0e4, 32'h2000);
        wb(1'b1, 12'h010, 32'h73);
        xfer(16'h0010, 1, 32'h10002000, 1'b1);
        xfer(16'h0010, 2, 32'h10022000, 1'b1);
        rdchk(12'h084, 32'h10000);
        rdchk(12'h0c4, 32'h1004);
        chk(n_taken, 32'h2);
        pulse(16'h0010, 8'h00);
        vec(8'h03, 32'h24);
        chk(n_xfer, 32'h2);
        wb(1'b1, 12'h088, 32'h60000);
        wb(1'b1, 12'h0c8, 32'h4000);
        wb(1'b1, 12'h0e8, 32'h3000);
        wb(1'b1, 12'h018, 32'hb3);
        xfer(16'h0040, 3, 32'h40003000, 1'b0);
        xfer(16'h0040, 4, 32'h40003001, 1'b0);
        rdchk(12'h088, 32'h60000);
        $display("test transfers finished");
        psw_level <= 4'hf;
        pulse(16'h0000, 8'h08);
        vec(8'h04, 32'h103);
        rdchk(12'h100, 32'h8);
        wb(1'b1, 12'h100, 32'h8);
        rdchk(12'h100, 32'h0);
        psw_level <= 4'h0;
        pulse(16'h0044, 8'h00);
        repeat (60) @(posedge clk_sys);
        chk(n_taken, 32'h4);
        chk(n_xfer, 32'h4);
        ret();
        vec(8'h05, 32'h22);
        xfer(16'h0000, 5, 32'h40003002, 1'b0);
        psw_level <= 4'hf;
        pulse(16'h0000, 8'h22);
        vec(8'h06, 32'h101);
        repeat (30) @(posedge clk_sys);
        chk(n_taken, 32'h6);
        ret();
        vec(8'h07, 32'h105);
        ret();
        @(posedge clk_sys);
        sw_trap_num <= 8'h41;
        sw_trap <= 1'b1;
        @(posedge clk_sys);
        sw_trap <= 1'b0;
        vec(8'h08, 32'h241);
        $display("test traps finished");
        test_done();
    end
endmodule : piec_top_bench
